/* File: bseo_pkg.sv */
package bseo_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each).
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_ZERO_SPD  = 8'h04;
  localparam logic [7:0] ADDR_STAT_DLY  = 8'h08;
  localparam logic [7:0] ADDR_RUN_DLY   = 8'h0c;
  localparam logic [7:0] ADDR_BRK_SPD   = 8'h10;
  localparam logic [7:0] ADDR_DIV_NUM   = 8'h14;
  localparam logic [7:0] ADDR_DIV_DEN   = 8'h18;
  localparam logic [7:0] ADDR_Z_WIDTH   = 8'h1c;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------------------
  localparam int          CTRL_DIR_BIT   = 0;
  localparam logic [15:0] RST_ZERO_SPD   = 16'h0014;
  localparam logic [15:0] RST_STAT_DLY   = 16'h0064;
  localparam logic [15:0] RST_RUN_DLY    = 16'h01f4;
  localparam logic [15:0] RST_BRK_SPD    = 16'h001e;
  localparam logic [15:0] RST_DIV_NUM    = 16'h0001;
  localparam logic [15:0] RST_DIV_DEN    = 16'h0001;
  localparam logic [15:0] RST_Z_WIDTH    = 16'h0001;

  // ---------------------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int DLY_UNIT_US  = 1000;
  localparam int DLY_UNIT_CYC = CLK_HZ / 1_000_000 * DLY_UNIT_US;
  localparam int Z_UNIT_US    = 50;
  localparam int Z_UNIT_CYC   = CLK_HZ / 1_000_000 * Z_UNIT_US;

  // Brake sequencer states.
  typedef enum logic [2:0] {
    BS_DISABLED,
    BS_ENABLED,
    BS_STAT_WAIT,
    BS_RUN_WAIT
  } bseo_brk_state_t;

endpackage

/* File: bseo_tick.sv */
`timescale 1ns/1ns
// One-cycle pulse every DIV clocks; used as a time base.
module bseo_tick #(
  parameter int DIV = 50000
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Tick out.
  output logic      tick
);

  logic [31:0] cnt_q;

  // Free-running counter; restarts at reset so delays are repeatable.
  always_ff @(posedge clk) begin
    if (rst || cnt_q == 32'(DIV - 1)) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  assign tick = (cnt_q == 32'(DIV - 1));

endmodule

/* File: bseo_quad.sv */
`timescale 1ns/1ns
// Quadrature state stepper: one step forward or back per request.
module bseo_quad (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Step request.
  input  wire logic step,
  input  wire logic dir_up,
  // Phase outputs.
  output logic      pha,
  output logic      phb
);

  logic [1:0] ph_q;

  // Gray sequence 00,01,11,10 gives A leading B by 90 degrees when up.
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q <= 2'h0;
    end else if (step) begin
      ph_q <= dir_up ? ph_q + 2'h1 : ph_q - 2'h1;
    end
  end

  assign pha = ph_q[1] ^ ph_q[0];
  assign phb = ph_q[1];

endmodule

/* File: bseo_top.sv */
`timescale 1ns/1ns
// Operation
// - Enabled to disabled or alarm starts the brake sequence.
// - Stationary: engage brake, wait stationary delay, then cut current.
// - Speed below zero-speed threshold is stationary, at or above running.
// - Running: cut current first, engage brake after running delay.
// - Running: brake engages at delay expiry or brake speed, first wins.
// - Output pulse rate is feedback rate times numerator over denominator.
// - Numerator above denominator passes feedback pulses one for one.
// - Index pulse width is the reset width RST_Z_WIDTH times 50 microseconds.
// - New index width never takes effect; reset reloads RST_Z_WIDTH before the copy.
// - Direction 0 keeps A/B phase; 1 reverses it.
// - Speed compared as absolute value regardless of direction.
module bseo_top (
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // AXI4-Lite write address.
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // AXI4-Lite write data.
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response.
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address.
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // AXI4-Lite read data.
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Drive state and speed from the control core.
  input  wire logic        DRIVE_ENABLED,
  input  wire logic        DRIVE_ALARM,
  input  wire logic [15:0] MOTOR_SPEED,
  // Encoder feedback pins.
  input  wire logic        ENC_A,
  input  wire logic        ENC_B,
  input  wire logic        ENC_Z,
  // Power stage and brake.
  output logic             CURRENT_ON,
  output logic             BRAKE_RELEASE_OUT,
  // Emulated encoder outputs.
  output logic             EMULATED_PHASE_A_OUT,
  output logic             EMULATED_PHASE_B_OUT,
  output logic             EMULATED_INDEX_OUT
);

  // ---------------------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------------------
  logic        dir_q;
  logic [15:0] zero_spd_q, stat_dly_q, run_dly_q, brk_spd_q;
  logic [15:0] div_num_q, div_den_q, z_width_q, z_width_live_q;
  logic        pwr_first_q;

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave.
  // ---------------------------------------------------------------------------
  logic [7:0]  awaddr_q;
  logic        aw_have_q, w_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        wr_ok;
  logic [31:0] rd_val;
  logic        rd_ok;
  bseo_pkg::bseo_brk_state_t st_q;

  assign do_write = aw_have_q && w_have_q && !S_AXI_BVALID;

  // Address and data are latched separately so either may arrive first.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_have_q && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_ok ? 2'h0 : 2'h2;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_comb begin
    wr_ok = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= bseo_pkg::ADDR_Z_WIDTH);
  end

  // Register writes honour the two low byte lanes.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0]  = nw[7:0];
    if (st[1]) r[15:8] = nw[15:8];
    return r;
  endfunction

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dir_q      <= 1'b0;
      zero_spd_q <= bseo_pkg::RST_ZERO_SPD;
      stat_dly_q <= bseo_pkg::RST_STAT_DLY;
      run_dly_q  <= bseo_pkg::RST_RUN_DLY;
      brk_spd_q  <= bseo_pkg::RST_BRK_SPD;
      div_num_q  <= bseo_pkg::RST_DIV_NUM;
      div_den_q  <= bseo_pkg::RST_DIV_DEN;
      z_width_q  <= bseo_pkg::RST_Z_WIDTH;
    end else if (do_write && wr_ok) begin
      case (awaddr_q)
        bseo_pkg::ADDR_CTRL:
          if (wstrb_q[0]) dir_q <= wdata_q[bseo_pkg::CTRL_DIR_BIT];
        bseo_pkg::ADDR_ZERO_SPD:
          zero_spd_q <= merge16(zero_spd_q, wdata_q, wstrb_q);
        bseo_pkg::ADDR_STAT_DLY:
          stat_dly_q <= merge16(stat_dly_q, wdata_q, wstrb_q);
        bseo_pkg::ADDR_RUN_DLY:
          run_dly_q  <= merge16(run_dly_q, wdata_q, wstrb_q);
        bseo_pkg::ADDR_BRK_SPD:
          brk_spd_q  <= merge16(brk_spd_q, wdata_q, wstrb_q);
        bseo_pkg::ADDR_DIV_NUM:
          div_num_q  <= merge16(div_num_q, wdata_q, wstrb_q);
        bseo_pkg::ADDR_DIV_DEN:
          div_den_q  <= merge16(div_den_q, wdata_q, wstrb_q);
        bseo_pkg::ADDR_Z_WIDTH:
          z_width_q  <= merge16(z_width_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // Index width is copied only once after reset (power-up); later writes
  // are stored and read back but never copied; reset reloads RST_Z_WIDTH first.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pwr_first_q    <= 1'b1;
      z_width_live_q <= 16'h0000;
    end else if (pwr_first_q) begin
      pwr_first_q    <= 1'b0;
      z_width_live_q <= z_width_q;
    end
  end

  // Read decode.
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (S_AXI_ARADDR)
      bseo_pkg::ADDR_CTRL:     rd_val = {31'h0, dir_q};
      bseo_pkg::ADDR_ZERO_SPD: rd_val = {16'h0, zero_spd_q};
      bseo_pkg::ADDR_STAT_DLY: rd_val = {16'h0, stat_dly_q};
      bseo_pkg::ADDR_RUN_DLY:  rd_val = {16'h0, run_dly_q};
      bseo_pkg::ADDR_BRK_SPD:  rd_val = {16'h0, brk_spd_q};
      bseo_pkg::ADDR_DIV_NUM:  rd_val = {16'h0, div_num_q};
      bseo_pkg::ADDR_DIV_DEN:  rd_val = {16'h0, div_den_q};
      bseo_pkg::ADDR_Z_WIDTH:  rd_val = {16'h0, z_width_q};
      bseo_pkg::ADDR_STATUS:   rd_val = {8'h0, z_width_live_q, 8'h0}
                                        | {29'h0, 3'(st_q)}
                                        | {27'h0, CURRENT_ON,
                                           BRAKE_RELEASE_OUT, 3'h0};
      default:                 rd_ok = 1'b0;
    endcase
  end

  // Read channel: address taken in one cycle, data the next.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= 2'h0;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_val;
        S_AXI_RRESP  <= rd_ok ? 2'h0 : 2'h2;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Brake sequencer.
  // ---------------------------------------------------------------------------
  logic [15:0] spd_abs;
  logic        stationary, ms_tick, en_now, en_prev_q, tick_clr;
  logic [15:0] dly_cnt_q;

  bseo_tick #(
    .DIV (bseo_pkg::DLY_UNIT_CYC)
  ) u_ms (
    .clk  (REF_CLK),
    .rst  (tick_clr),
    .tick (ms_tick)
  );

  // Speed is two's complement; the sign is dropped before comparing.
  assign spd_abs    = MOTOR_SPEED[15] ? 16'(-MOTOR_SPEED) : MOTOR_SPEED;
  assign stationary = spd_abs < zero_spd_q;
  assign en_now     = DRIVE_ENABLED && !DRIVE_ALARM;
  // The time base restarts as a sequence begins, so no programmed delay is
  // cut short by a partly spent millisecond.
  assign tick_clr   = RST || (en_prev_q && !en_now
                      && st_q == bseo_pkg::BS_ENABLED);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_now;
    end
  end

  // Brake and current outputs are registered; release means brake open.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q              <= bseo_pkg::BS_DISABLED;
      CURRENT_ON        <= 1'b0;
      BRAKE_RELEASE_OUT <= 1'b0;
      dly_cnt_q         <= 16'h0000;
    end else begin
      case (st_q)
        bseo_pkg::BS_DISABLED: begin
          if (en_now) begin
            st_q              <= bseo_pkg::BS_ENABLED;
            CURRENT_ON        <= 1'b1;
            BRAKE_RELEASE_OUT <= 1'b1;
          end
        end
        bseo_pkg::BS_ENABLED: begin
          if (en_prev_q && !en_now) begin
            dly_cnt_q <= 16'h0000;
            if (stationary) begin
              BRAKE_RELEASE_OUT <= 1'b0;
              st_q              <= bseo_pkg::BS_STAT_WAIT;
            end else begin
              CURRENT_ON <= 1'b0;
              st_q       <= bseo_pkg::BS_RUN_WAIT;
            end
          end
        end
        bseo_pkg::BS_STAT_WAIT: begin
          if (dly_cnt_q >= stat_dly_q) begin
            CURRENT_ON <= 1'b0;
            st_q       <= bseo_pkg::BS_DISABLED;
          end else if (ms_tick) begin
            dly_cnt_q <= dly_cnt_q + 16'h0001;
          end
        end
        bseo_pkg::BS_RUN_WAIT: begin
          if (dly_cnt_q >= run_dly_q || spd_abs <= brk_spd_q) begin
            BRAKE_RELEASE_OUT <= 1'b0;
            st_q              <= bseo_pkg::BS_DISABLED;
          end else if (ms_tick) begin
            dly_cnt_q <= dly_cnt_q + 16'h0001;
          end
        end
        default: st_q <= bseo_pkg::BS_DISABLED;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Encoder emulation.
  // ---------------------------------------------------------------------------
  logic [2:0] a_sy_q, b_sy_q, z_sy_q;
  logic       fb_step, fb_up, out_step, pa, pb;
  logic [16:0] acc_q;
  logic        pass_thru;

  // Pins go through two flops; the third stage feeds edge detection only.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      a_sy_q <= 3'h0;
      b_sy_q <= 3'h0;
      z_sy_q <= 3'h0;
    end else begin
      a_sy_q <= {a_sy_q[1:0], ENC_A};
      b_sy_q <= {b_sy_q[1:0], ENC_B};
      z_sy_q <= {z_sy_q[1:0], ENC_Z};
    end
  end

  // Every A or B edge is one count; direction from the quadrature relation.
  assign fb_step = (a_sy_q[2] ^ a_sy_q[1]) | (b_sy_q[2] ^ b_sy_q[1]);
  assign fb_up   = (a_sy_q[2] ^ a_sy_q[1]) ? (a_sy_q[1] ^ b_sy_q[1])
                                           : !(b_sy_q[1] ^ a_sy_q[1]);
  assign pass_thru = (div_num_q > div_den_q) || (div_den_q == 16'h0000);

  // Fractional accumulator: adds numerator, emits a step on overflow.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_q <= 17'h00000;
    end else if (fb_step && !pass_thru) begin
      if (acc_q + 17'(div_num_q) >= 17'(div_den_q)) begin
        acc_q <= acc_q + 17'(div_num_q) - 17'(div_den_q);
      end else begin
        acc_q <= acc_q + 17'(div_num_q);
      end
    end
  end

  assign out_step = fb_step && (pass_thru
                    || (acc_q + 17'(div_num_q) >= 17'(div_den_q)));

  bseo_quad u_quad (
    .clk    (REF_CLK),
    .rst    (RST),
    .step   (out_step),
    .dir_up (fb_up),
    .pha    (pa),
    .phb    (pb)
  );

  // Swapping A and B reverses which phase leads.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      EMULATED_PHASE_A_OUT <= 1'b0;
      EMULATED_PHASE_B_OUT <= 1'b0;
    end else begin
      EMULATED_PHASE_A_OUT <= dir_q ? pb : pa;
      EMULATED_PHASE_B_OUT <= dir_q ? pa : pb;
    end
  end

  // Index stretcher, counted in 50 us units.
  logic [31:0] z_cnt_q;
  logic [31:0] z_len;
  assign z_len = 32'(z_width_live_q) * 32'(bseo_pkg::Z_UNIT_CYC);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      z_cnt_q            <= 32'h0000_0000;
      EMULATED_INDEX_OUT <= 1'b0;
    end else if (z_cnt_q != 32'h0000_0000) begin
      z_cnt_q            <= z_cnt_q - 32'h0000_0001;
      EMULATED_INDEX_OUT <= (z_cnt_q != 32'h0000_0001);
    end else if (z_sy_q[1] && !z_sy_q[2] && z_len != 32'h0000_0000) begin
      z_cnt_q            <= z_len;
      EMULATED_INDEX_OUT <= 1'b1;
    end else begin
      EMULATED_INDEX_OUT <= 1'b0;
    end
  end

endmodule

/* File: bseo_top_sva.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the brake and encoder block.
// ----------------------------------------
module bseo_chk (
  // Clock and reset.
  input wire logic        REF_CLK,
  input wire logic        RST,
  // Bus handshakes.
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // Drive state and pins.
  input wire logic        DRIVE_ENABLED,
  input wire logic        DRIVE_ALARM,
  input wire logic        ENC_A,
  input wire logic        ENC_B,
  input wire logic        CURRENT_ON,
  input wire logic        BRAKE_RELEASE_OUT,
  input wire logic        EMULATED_PHASE_A_OUT,
  input wire logic        EMULATED_PHASE_B_OUT,
  input wire logic        EMULATED_INDEX_OUT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic        en;
  logic        en_q;
  logic [31:0] zc_q;
  assign en = DRIVE_ENABLED && !DRIVE_ALARM;
  // Enable history, so the leaving edge is seen as the sequencer sees it.
  always_ff @(posedge REF_CLK) begin
    en_q <= RST ? 1'b0 : en;
  end
  // Index length; a whole number of units must end each pulse.
  always_ff @(posedge REF_CLK) begin
    zc_q <= (RST || !EMULATED_INDEX_OUT) ? 32'h0 : zc_q + 32'h1;
  end
  sequence s_leave;
    en_q && !en && CURRENT_ON && BRAKE_RELEASE_OUT;
  endsequence
  sequence s_pins_quiet;
    ($stable(ENC_A) && $stable(ENC_B)) [*6];
  endsequence
  a_one_drops: assert property (s_leave |-> ##[1:2]
    (CURRENT_ON != BRAKE_RELEASE_OUT)) else $error("one output must drop");
  a_idle_low: assert property (!en && !CURRENT_ON && !BRAKE_RELEASE_OUT
    |=> !CURRENT_ON && !BRAKE_RELEASE_OUT) else $error("idle output rose");
  a_enable_on: assert property (!en_q && en && !CURRENT_ON
    && !BRAKE_RELEASE_OUT |-> ##[1:2] (CURRENT_ON && BRAKE_RELEASE_OUT))
    else $error("enable did not raise outputs");
  a_index_len: assert property ($fell(EMULATED_INDEX_OUT) |->
    (zc_q % bseo_pkg::Z_UNIT_CYC == 0)) else $error("index width wrong");
  a_index_hold: assert property ($rose(EMULATED_INDEX_OUT)
    |=> EMULATED_INDEX_OUT [*8]) else $error("index pulse too short");
  a_quad_quiet: assert property (s_pins_quiet |->
    $stable(EMULATED_PHASE_A_OUT) && $stable(EMULATED_PHASE_B_OUT))
    else $error("output stepped without input");
  a_quad_gray: assert property ($changed(EMULATED_PHASE_A_OUT)
    |-> $stable(EMULATED_PHASE_B_OUT)) else $error("both phases moved");
  a_b_answer: assert property (S_AXI_AWREADY && S_AXI_WREADY
    |-> ##2 S_AXI_BVALID) else $error("write response late");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID) else $error("write response dropped");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
endmodule

/* File: bseo_ctrl_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Motion controller input: quadrature counter and index timer.
// ----------------------------------------
module bseo_ctrl_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Emulated encoder lines.
  input  wire logic        a,
  input  wire logic        b,
  input  wire logic        z,
  // Decoded results.
  output logic signed [15:0] pos,
  output logic [15:0]        z_seen,
  output logic [31:0]        z_len
);
  logic [1:0]  pv_q;
  logic [31:0] zc_q;
  logic        z_q;
  logic [1:0]  cur;
  // Gray position: A leading B counts up.
  assign cur = {b, a ^ b};
  // Four-fold decode; an illegal double step is simply not counted.
  always_ff @(posedge clk) begin
    pv_q <= rst ? 2'h0 : cur;
    if (rst) pos <= 16'sh0;
    else if (cur - pv_q == 2'h1) pos <= pos + 16'sh1;
    else if (cur - pv_q == 2'h3) pos <= pos - 16'sh1;
  end
  // Index pulses are counted and their length kept.
  always_ff @(posedge clk) begin
    z_q <= rst ? 1'b0 : z;
    zc_q <= (rst || !z) ? 32'h0 : zc_q + 32'h1;
    if (rst) z_seen <= 16'h0;
    else if (z && !z_q) z_seen <= z_seen + 16'h1;
    if (rst) z_len <= 32'h0;
    else if (!z && z_q) z_len <= zc_q;
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the brake sequencer and encoder output.
// ----------------------------------------
module testbench;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        en, alarm, enc_a, enc_b, enc_z;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, seed, rd, zs0;
  logic [15:0] speed;
  logic [1:0]  resp, p;
  logic signed [15:0] p0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   cur_on, brk_rel, out_a, out_b, out_z;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata, z_len;
  wire logic [15:0] z_seen;
  wire logic signed [15:0] pos;
  int          err_total, checks, cyc, n, net;
  bseo_top u_dut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .DRIVE_ENABLED(en), .DRIVE_ALARM(alarm),
    .MOTOR_SPEED(speed), .ENC_A(enc_a), .ENC_B(enc_b), .ENC_Z(enc_z),
    .CURRENT_ON(cur_on), .BRAKE_RELEASE_OUT(brk_rel),
    .EMULATED_PHASE_A_OUT(out_a), .EMULATED_PHASE_B_OUT(out_b),
    .EMULATED_INDEX_OUT(out_z));
  bseo_ctrl_model u_ctrl (.clk(clk), .rst(rst), .a(out_a), .b(out_b),
    .z(out_z), .pos(pos), .z_seen(z_seen), .z_len(z_len));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic print_verdict();
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] expv);
    checks = checks + 1;
    if (seen !== expv) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  // Bus master; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      aw_ok = aw_ok || (awready === 1'b1);
      w_ok = w_ok || (wready === 1'b1);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // One quadrature step, spaced well beyond the output latency.
  task automatic step(input logic up);
    p = up ? p + 2'h1 : p - 2'h1;
    @(posedge clk);
    enc_a <= p[0] ^ p[1];
    enc_b <= p[1];
    repeat (7) @(posedge clk);
  endtask
  task automatic enc_fwd(input string nm, input int k, input int expv);
    p0 = pos;
    repeat (k) step(1'b1);
    chk(nm, 32'(pos - p0), 32'(expv));
  endtask
  task automatic zpulse();
    @(posedge clk);
    enc_z <= 1'b1;
    repeat (2) @(posedge clk);
    enc_z <= 1'b0;
  endtask
  // Enable, then leave by disable or alarm and look at the first move.
  task automatic brake_release_out(input string nm, input logic [15:0] spd,
                     input logic via_alarm, input logic stat);
    @(posedge clk);
    speed <= spd;
    alarm <= 1'b0;
    en <= 1'b1;
    repeat (4) @(negedge clk);
    chk(nm, {cur_on, brk_rel}, 2'b11);
    @(posedge clk);
    if (via_alarm) alarm <= 1'b1;
    else en <= 1'b0;
    repeat (3) @(negedge clk);
    chk(nm, {cur_on, brk_rel}, stat ? 2'b10 : 2'b01);
  endtask
  // Free-running clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h21;
    {en, alarm, enc_a, enc_b, enc_z} = 5'h00;
    {awaddr, araddr, wdata, speed, p} = 66'h0;
    seed = 32'h00012e0a;
    {err_total, checks, cyc} = 96'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset outs", {cur_on, brk_rel, out_a, out_b, out_z}, 5'h00);
    rd_reg(bseo_pkg::ADDR_ZERO_SPD);
    chk("zero spd", rd, 32'(bseo_pkg::RST_ZERO_SPD));
    rd_reg(8'h40);
    chk("bad rd", rd, 32'h0);
    chk("bad rresp", resp, 2'h2);
    wr(8'h40, seed);
    chk("bad wr", resp, 2'h2);
    seed = xs(seed);
    wr(bseo_pkg::ADDR_RUN_DLY, {16'h0, seed[15:0]});
    rd_reg(bseo_pkg::ADDR_RUN_DLY);
    chk("run dly", rd, {16'h0, seed[15:0]});
    // Random walk at 1:1, then the ratio and direction cases.
    p0 = pos;
    net = 0;
    repeat (24) begin
      seed = xs(seed);
      step(seed[0]);
      net = net + (seed[0] ? 1 : -1);
    end
    chk("ratio one", 32'(pos - p0), 32'(net));
    wr(bseo_pkg::ADDR_DIV_DEN, 32'h2);
    enc_fwd("ratio half", 40, 20);
    wr(bseo_pkg::ADDR_DIV_NUM, 32'h3);
    enc_fwd("ratio over", 10, 10);
    // Swap only while A equals B, so the outputs do not jump.
    while (out_a !== out_b) step(1'b1);
    wr(bseo_pkg::ADDR_CTRL, 32'h1);
    enc_fwd("reversed", 10, -10);
    while (out_a !== out_b) step(1'b1);
    wr(bseo_pkg::ADDR_CTRL, 32'h0);
    enc_fwd("normal", 6, 6);
    // Brake: stationary just under the threshold, then running cases.
    wr(bseo_pkg::ADDR_ZERO_SPD, 32'h64);
    wr(bseo_pkg::ADDR_STAT_DLY, 32'h1);
    wr(bseo_pkg::ADDR_BRK_SPD, 32'h1e);
    wr(bseo_pkg::ADDR_RUN_DLY, 32'h1);
    brake_release_out("stat", 16'hff9d, 1'b0, 1'b1);
    n = 3;
    while (cur_on === 1'b1 && n < 60000) begin
      @(negedge clk);
      n = n + 1;
    end
    chk("stat dly", 32'(n >= 50000 && n <= 50008), 32'h1);
    seed = xs(seed);
    brake_release_out("run", 16'hff00 - {6'h00, seed[9:0]}, 1'b1, 1'b0);
    repeat (50) @(negedge clk);
    chk("run hold", brk_rel, 1'b1);
    @(posedge clk);
    speed <= 16'hffe2 + {11'h0, seed[14:10]};
    repeat (6) @(negedge clk);
    chk("run slow", brk_rel, 1'b0);
    brake_release_out("edge", 16'h0064, 1'b0, 1'b0);
    @(posedge clk);
    speed <= 16'h0000;
    repeat (6) @(negedge clk);
    chk("edge slow", brk_rel, 1'b0);
    // Index: a second event while stretching must not retrigger.
    zs0 = 32'(z_seen);
    zpulse();
    repeat (500) @(posedge clk);
    zpulse();
    repeat (3000) @(negedge clk);
    chk("z width", z_len, 32'(bseo_pkg::Z_UNIT_CYC));
    chk("z count", 32'(z_seen) - zs0, 32'h1);
    wr(bseo_pkg::ADDR_Z_WIDTH, 32'h2);
    rd_reg(bseo_pkg::ADDR_STATUS);
    chk("z live", rd[23:8], 32'(bseo_pkg::RST_Z_WIDTH));
    zpulse();
    repeat (3000) @(negedge clk);
    chk("z kept", z_len, 32'(bseo_pkg::Z_UNIT_CYC));
    chk("z count 2", 32'(z_seen) - zs0, 32'h2);
    print_verdict();
  end
endmodule
bind bseo_top bseo_chk u_chk (.*);
